// File: src/incr_or_move_jump_exec_regs.vh
// constants for the increment / or / move / jump execution block
`ifndef INCR_OR_MOVE_JUMP_EXEC_REGS_VH
`define INCR_OR_MOVE_JUMP_EXEC_REGS_VH
// 14-bit instruction opcode fields
`define OPC_FILE_HI 13
`define OPC_FILE_LO 8
`define OPC_LIT_HI 13
`define OPC_LIT_LO 8
`define OPC_JMP_HI 13
`define OPC_JMP_LO 11
`define OPC_INCR_SKIP 6'h0f
`define OPC_INCR 6'h0a
`define OPC_OR_FILE 6'h04
`define OPC_MOVE_FILE 6'h08
`define OPC_OR_LIT 6'h38
`define OPC_OR_LIT_MASK 6'h3e
`define OPC_JUMP 3'h5
// operand fields
`define DEST_BIT 7
`define FADDR_HI 6
`define FADDR_LO 0
`define LIT8_HI 7
`define LIT8_LO 0
`define LIT11_HI 10
`define LIT11_LO 0
`define PCL_UP_HI 4
`define PCL_UP_LO 3
// values
`define DEST_ACC 1'b0
`define ONE8 8'h01
`define ZERO8 8'h00
`define ACC_RST 8'h00
`define PC_RST 13'h0000
`define FLAG_CLR 1'b0
`define FADDR_RST 7'h00
`define PC_STEP 13'h0001
`endif

// File: src/incr_or_move_jump_exec.v
// execution unit for skip-increment, increment, jump, or-literal, or-file and move-file
`timescale 1ns/100ps
`default_nettype none
`include "incr_or_move_jump_exec_regs.vh"

// Functional notes
// - skip-increment adds one, flags untouched
// - zero result turns next instruction into nop
// - file address 0..127, target 0=acc, 1=file
// - jump loads 11-bit literal, upper from latch
// - jump takes two cycles, flags untouched
// - or-literal ors acc, result acc, zero updated
// - increment adds one, zero flag updated
// - or-file ors acc and file, zero updated
// - move-file copies to chosen target, zero updated
// - move onto itself tests zero, value kept
module incr_or_move_jump_exec (
    input wire clk,
    input wire rstn,
    input wire instr_valid, // one instruction offered per cycle
    input wire [13:0] instr, // fetched instruction word
    input wire [7:0] file_rdata, // addressed file register contents
    input wire [7:0] upper_pc_latch, // upper program counter latch
    output wire instr_ready, // high when a new instruction is accepted
    output wire [6:0] file_addr, // combinational read address
    output reg file_we, // write strobe into file register
    output reg [6:0] file_waddr, // write address
    output reg [7:0] file_wdata, // write data
    output reg [7:0] acc, // accumulator
    output reg zero_flag, // status zero flag
    output reg [12:0] pc, // program counter
    output reg busy // second cycle of a two-cycle instruction
);

    // one-hot states
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_FLUSH = 2'b10;

    reg [1:0] state_q; // current state
    reg [1:0] state_d; // next state

    // decoded operation class of a word
    localparam [2:0] K_NONE = 3'h0;
    localparam [2:0] K_ISKIP = 3'h1;
    localparam [2:0] K_INCR = 3'h2;
    localparam [2:0] K_ORF = 3'h3;
    localparam [2:0] K_MOVE_FILE_OP = 3'h4;
    localparam [2:0] K_ORL = 3'h5;
    localparam [2:0] K_JMP = 3'h6;

    // decode an instruction word into its class
    function [2:0] op_class;
        input [13:0] w;
        begin
            op_class = K_NONE;
            if (w[`OPC_JMP_HI:`OPC_JMP_LO] == `OPC_JUMP)
                op_class = K_JMP;
            else if ((w[`OPC_LIT_HI:`OPC_LIT_LO] & `OPC_OR_LIT_MASK) == `OPC_OR_LIT)
                op_class = K_ORL;
            else if (w[`OPC_FILE_HI:`OPC_FILE_LO] == `OPC_INCR_SKIP)
                op_class = K_ISKIP;
            else if (w[`OPC_FILE_HI:`OPC_FILE_LO] == `OPC_INCR)
                op_class = K_INCR;
            else if (w[`OPC_FILE_HI:`OPC_FILE_LO] == `OPC_OR_FILE)
                op_class = K_ORF;
            else if (w[`OPC_FILE_HI:`OPC_FILE_LO] == `OPC_MOVE_FILE)
                op_class = K_MOVE_FILE_OP;
        end
    endfunction

    // zero test shared by the skip decision and the zero flag
    function is_zero;
        input [7:0] v; // eight-bit result
        begin
            is_zero = (v == `ZERO8);
        end
    endfunction

    wire [2:0] kind = op_class(instr); // class of offered word
    wire dest_file = instr[`DEST_BIT]; // result target select
    wire [7:0] lit8 = instr[`LIT8_HI:`LIT8_LO]; // eight-bit literal
    wire run = (state_q == ST_RUN); // executing, not flushing
    wire go = instr_valid && run; // instruction executes this cycle

    assign instr_ready = run; // flush cycle swallows the next word
    assign file_addr = instr[`FADDR_HI:`FADDR_LO]; // 7-bit address covers 0..127

    reg [7:0] result; // alu result
    reg writes_result; // class produces a destination result
    reg sets_zero; // class updates zero flag
    reg two_cycle; // class needs a flush cycle

    // alu and cycle-count selection
    always @*
    begin
        result = `ZERO8;
        writes_result = 1'b0;
        sets_zero = 1'b0;
        two_cycle = 1'b0;
        case (kind)
            K_ISKIP:
            begin
                result = file_rdata + `ONE8;
                writes_result = 1'b1;
                two_cycle = is_zero(result); // skip only on zero
            end
            K_INCR:
            begin
                result = file_rdata + `ONE8;
                writes_result = 1'b1;
                sets_zero = 1'b1;
            end
            K_ORF:
            begin
                result = acc | file_rdata;
                writes_result = 1'b1;
                sets_zero = 1'b1;
            end
            K_MOVE_FILE_OP:
            begin
                result = file_rdata; // write-back of same value keeps it
                writes_result = 1'b1;
                sets_zero = 1'b1;
            end
            K_ORL:
            begin
                result = acc | lit8;
                sets_zero = 1'b1;
            end
            K_JMP:
            begin
                two_cycle = 1'b1;
            end
            default:
            begin
                result = `ZERO8;
            end
        endcase
    end

    // next state: flush follows a jump or a zero skip
    always @*
    begin
        case (state_q)
            ST_RUN:
                state_d = (go && two_cycle) ? ST_FLUSH : ST_RUN;
            ST_FLUSH:
                state_d = ST_RUN; // exactly one lost cycle
            default:
                state_d = ST_RUN;
        endcase
    end

    // which destination an executing word writes
    wire to_acc = go && ((kind == K_ORL) || (writes_result && (dest_file == `DEST_ACC)));
    wire to_file = go && writes_result && (dest_file != `DEST_ACC); // target 1 writes back
    wire is_jump = go && (kind == K_JMP); // jump taken this cycle

    reg [12:0] pc_d; // next program counter

    // next program counter
    // the refused slot still steps the counter, so after a jump or a skip the
    // next accepted word sits one step past the value loaded or stepped
    always @*
    begin
        pc_d = pc; // idle cycles hold the counter
        if (!run)
        begin
            pc_d = pc + `PC_STEP; // skipped slot still advances
        end
        else if (is_jump)
        begin
            pc_d = {upper_pc_latch[`PCL_UP_HI:`PCL_UP_LO], instr[`LIT11_HI:`LIT11_LO]};
        end
        else if (go)
        begin
            pc_d = pc + `PC_STEP; // single-cycle step
        end
        else
        begin
            pc_d = pc; // nothing offered, nothing moves
        end
    end

    // sequencer state; one refused slot follows a jump or a zero skip
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_RUN; // ready straight out of reset
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // busy marks the refused slot as a registered output
    // registered rather than decoded from state so the pin never glitches
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= `FLAG_CLR;
        end
        else
        begin
            busy <= (state_d == ST_FLUSH); // high exactly in the lost cycle
        end
    end

    // program counter register
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc <= `PC_RST;
        end
        else
        begin
            pc <= pc_d;
        end
    end

    // accumulator; or-literal ignores the target bit and always lands here
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc <= `ACC_RST;
        end
        else if (to_acc)
        begin
            acc <= result; // target 0 or or-literal
        end
        else
        begin
            acc <= acc; // a file target leaves the accumulator alone
        end
    end

    // zero flag; skip-increment and jump leave it untouched
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            zero_flag <= `FLAG_CLR;
        end
        else if (go && sets_zero)
        begin
            zero_flag <= is_zero(result);
        end
        else
        begin
            zero_flag <= zero_flag; // flags untouched
        end
    end

    // file write port: a one-cycle strobe with address and data behind it
    // address and data keep their last value between writes, so the file side
    // must qualify them with the strobe
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            file_we <= `FLAG_CLR;
            file_waddr <= `FADDR_RST;
            file_wdata <= `ZERO8;
        end
        else
        begin
            file_we <= to_file; // one pulse per write-back
            if (to_file)
            begin
                file_waddr <= file_addr; // 0..127
                file_wdata <= result; // same value back only tests zero
            end
        end
    end

endmodule // incr_or_move_jump_exec
`default_nettype wire

// File: test/incr_or_move_jump_exec_sva.sv
// port-level assertions for the execution block
`timescale 1ns/100ps
`default_nettype none
module incr_or_move_jump_exec_sva (
    input wire clk,
    input wire rstn,
    input wire instr_valid,
    input wire [13:0] instr,
    input wire [7:0] file_rdata,
    input wire [7:0] upper_pc_latch,
    input wire instr_ready,
    input wire [6:0] file_addr,
    input wire file_we,
    input wire [6:0] file_waddr,
    input wire [7:0] file_wdata,
    input wire [7:0] acc,
    input wire zero_flag,
    input wire [12:0] pc,
    input wire busy
);
    // accepted word, its opcode and the results it should give
    wire t = instr_valid & instr_ready;
    wire [5:0] op = instr[13:8];
    wire sk = t & (op == 6'h0f);
    wire mv = t & (op == 6'h08);
    wire wf = t & ((op == 6'h0f) | (op == 6'h0a) | (op == 6'h04) | (op == 6'h08));
    wire fz = (file_rdata == 8'h00);
    wire j = t & (instr[13:11] == 3'h5);
    wire [12:0] jt = {upper_pc_latch[4:3], instr[10:0]};
    wire [7:0] inc = file_rdata + 8'h01;
    wire [7:0] orl = acc | instr[7:0];
    wire [7:0] orf = acc | file_rdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_skip_flag: assert property (sk |=> $stable(zero_flag)) else $error("skip moved zero");
    chk_skip_nop: assert property (sk && file_rdata == 8'hff |=> busy && !instr_ready ##1 !busy)
        else $error("no nop slot");
    chk_skip_one: assert property (sk && file_rdata != 8'hff |=> !busy && instr_ready)
        else $error("skip took two cycles");
    chk_file_addr: assert property (file_addr == instr[6:0]) else $error("bad file addr");
    chk_wr_addr: assert property (wf && instr[7] |=> file_we && file_waddr == $past(instr[6:0]))
        else $error("bad write addr");
    chk_jump_pc: assert property (j |=> pc == $past(jt)) else $error("bad jump pc");
    chk_jump_two: assert property (j |=> busy && $stable(zero_flag) ##1 !busy) else $error("bad jump slot");
    chk_orl_acc: assert property (t && op[5:1] == 5'h1c |=> acc == $past(orl)) else $error("bad or lit");
    chk_zero_set: assert property (t && op[5:1] == 5'h1c |=> zero_flag == (acc == 8'h00))
        else $error("bad zero");
    chk_incr_wr: assert property (t && op == 6'h0a && instr[7] |=> file_we && file_wdata == $past(inc))
        else $error("bad incr");
    chk_incr_zero: assert property (t && op == 6'h0a |=> zero_flag == ($past(inc) == 8'h00))
        else $error("bad incr zero");
    chk_orf_wr: assert property (t && op == 6'h04 && instr[7] |=> file_we && file_wdata == $past(orf))
        else $error("bad or file");
    chk_move_acc: assert property (mv && !instr[7] |=> acc == $past(file_rdata) && !busy)
        else $error("bad move");
    chk_move_self: assert property (mv && instr[7] |=> file_we && file_wdata == $past(file_rdata))
        else $error("move changed value");
    chk_move_zero: assert property (mv && instr[7] |=> $stable(acc) && zero_flag == $past(fz))
        else $error("bad move zero");
    // main scenarios seen
    cover property (t && op == 6'h0f && file_rdata == 8'hff);
    cover property (sk && file_rdata != 8'hff);
    cover property (j);
    cover property (t && op == 6'h08 && instr[7]);
endmodule // incr_or_move_jump_exec_sva
bind incr_or_move_jump_exec incr_or_move_jump_exec_sva i_incr_or_move_jump_exec_sva (
    .clk(clk),
    .rstn(rstn),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .upper_pc_latch(upper_pc_latch),
    .instr_ready(instr_ready),
    .file_addr(file_addr),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .acc(acc),
    .zero_flag(zero_flag),
    .pc(pc),
    .busy(busy)
);
`default_nettype wire

// File: test/incr_or_move_jump_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module incr_or_move_jump_exec_tb;
    logic clk = 0, rstn = 0, instr_valid = 0, instr_ready, file_we, zero_flag, busy, got = 0, m_z = 0;
    logic [13:0] instr = 0;
    logic [7:0] file_rdata = 0, upper_pc_latch = 0, file_wdata, acc, m_acc = 0, r;
    logic [6:0] file_addr, file_waddr;
    logic [6:0] qa[$];
    logic [12:0] pc, m_pc = 0;
    logic [31:0] seed = 32'h2203, e, g, q[$];
    logic [5:0] opc [6] = '{6'h0f, 6'h0a, 6'h04, 6'h08, 6'h38, 6'h2d};
    int err_count = 0, n_checks = 0;
    incr_or_move_jump_exec i_incr_or_move_jump_exec (
        .clk(clk),
        .rstn(rstn),
        .instr_valid(instr_valid),
        .instr(instr),
        .file_rdata(file_rdata),
        .upper_pc_latch(upper_pc_latch),
        .instr_ready(instr_ready),
        .file_addr(file_addr),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .acc(acc),
        .zero_flag(zero_flag),
        .pc(pc),
        .busy(busy)
    );
    // clock; watchdog far beyond the hundred or so cycles used
    initial forever #20 clk = ~clk;
    initial
    begin
        #300000;
        err_count++;
        stop_test();
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x)
        begin
            err_count++;
            $display("BAD %0s exp %h seen %h", n, x, s);
        end
    endtask
    task stop_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // offer one word, note the expected state, step over a refused slot
    task op(input logic [13:0] w, input logic [7:0] rd);
        logic d, b, j, z;
        upper_pc_latch = 8'(rnd());
        j = w[13:11] == 3'h5;
        d = w[7] & (w[13:12] == 2'h0);
        z = ~j;
        b = j;
        case (w[13:8])
            6'h0f, 6'h0a: r = rd + 8'h01;
            6'h04: r = m_acc | rd;
            6'h08: r = rd;
            default: r = j ? m_acc : m_acc | w[7:0];
        endcase
        if (w[13:8] == 6'h0f)
        begin
            z = 0;
            b = r == 8'h00;
        end
        if (z)
            m_z = r == 8'h00;
        if (!d)
            m_acc = r;
        m_pc = j ? {upper_pc_latch[4:3], w[10:0]} : m_pc + 13'h1;
        q.push_back({m_pc, b, m_z, m_acc, d, d ? r : 8'h00});
        qa.push_back(d ? w[6:0] : 7'h00);
        instr_valid = 1;
        instr = w;
        file_rdata = rd;
        @(posedge clk) #1;
        if (b)
        begin
            instr = 14'(rnd());
            m_pc = m_pc + 13'h1;
            @(posedge clk) #1;
        end
    endtask
    // watcher: one note per accepted word
    always @(posedge clk) got <= rstn & instr_valid & instr_ready;
    always @(negedge clk)
        if (got)
        begin
            e = q.pop_front();
            chk("state", {pc, busy, zero_flag, acc, file_we, file_we ? file_wdata : 8'h00}, e);
            chk("waddr", 32'(file_we ? file_waddr : 7'h00), 32'(qa.pop_front()));
            chk("addr", 32'(file_addr), 32'(instr[6:0]));
        end
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rstn = 1;
        op({6'h0f, 8'h85}, 8'h03);
        op({6'h0f, 8'h05}, 8'hff);
        op({6'h0f, 8'hff}, 8'hff);
        op({6'h0a, 8'h7f}, 8'hff);
        op({6'h38, 8'h00}, 8'h00);
        op({6'h04, 8'h81}, 8'h40);
        op({6'h39, 8'h5a}, 8'h00);
        op({6'h08, 8'h80}, 8'h00);
        op({6'h08, 8'h01}, 8'ha5);
        $display("file ops done");
        op({3'h5, 11'h7ff}, 8'h00);
        op({3'h5, 11'h000}, 8'h00);
        $display("jump done");
        for (int i = 0; i < 60; i++)
        begin
            g = rnd();
            if (g[31])
            begin
                instr_valid = 0;
                instr = 14'(rnd());
                @(posedge clk) #1;
            end
            op({opc[g[20:8] % 6], g[7:0]}, 8'(rnd()));
        end
        $display("random done");
        instr_valid = 0;
        repeat (2) @(posedge clk);
        chk("left", 32'(q.size()), 32'h0);
        stop_test();
    end
endmodule // incr_or_move_jump_exec_tb
`default_nettype wire
